/* src/ssr_pkg.sv */
// package for the supply status and level register bank
// assumes one core clock domain and a single AHB-Lite master
package ssr_pkg;

  // register byte offsets
  localparam logic [7:0] SUPPLY_HEALTH_STATUS_OFS = 8'h30;
  localparam logic [7:0] CORE_VOLTAGE_LEVEL_OFS = 8'h34;
  localparam logic [7:0] PLL_REGULATOR_LEVEL_OFS = 8'h40;
  localparam logic [7:0] IRQ_STATUS_OFS = 8'h50;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h54;

  // supply status field positions
  localparam int unsigned OSC_STABLE_BIT = 24;
  localparam int unsigned PLL_GOOD_BIT = 19;
  localparam int unsigned CORE_GOOD_BIT = 16;
  localparam int unsigned ANALOG_LIMIT_BIT = 9;
  localparam int unsigned CORE_LIMIT_BIT = 8;
  localparam int unsigned ANALOG_SOFTSTART_BIT = 1;
  localparam int unsigned CORE_SOFTSTART_BIT = 0;

  // widths and code ranges
  localparam int unsigned CORE_CODE_W = 7;
  localparam int unsigned PLL_CODE_W = 3;
  localparam int unsigned EVENT_W = 7;
  localparam int unsigned MODE_W = 2;
  localparam logic [6:0] CORE_CODE_MAX = 7'h46;
  localparam logic [2:0] PLL_CODE_MAX = 3'h6;

  // reset values
  localparam logic [6:0] CORE_CODE_RST = 7'h00;
  localparam logic [2:0] PLL_CODE_RST = 3'h0;
  localparam logic [6:0] IRQ_MASK_RST = 7'h00;

  // mode pin strap to reset level codes
  localparam logic [6:0] CORE_CODE_BY_MODE [4] = '{7'h28, 7'h2d, 7'h32, 7'h3c};
  localparam logic [2:0] PLL_CODE_BY_MODE [4] = '{3'h4, 3'h4, 3'h5, 3'h6};

  // cycles after reset release before the strap is taken
  localparam logic [1:0] STRAP_SETTLE_CYCLES = 2'h3;

  typedef struct packed {
    logic osc_stable;
    logic pll_supply_rail_good;
    logic core_supply_rail_good;
    logic analog_switching_converter_limit;
    logic core_switching_converter_limit;
    logic analog_switching_converter_softstart;
    logic core_switching_converter_softstart;
  } ssr_supply_t;

  typedef struct packed {
    logic [6:0] core_code;
    logic [2:0] pll_code;
  } ssr_level_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
  } ssr_bus_req_t;

endpackage : ssr_pkg

/* src/ssr_sync.sv */
// two flip-flop synchroniser for a group of pin levels
// assumes the inputs are quasi-static levels, not pulses
`timescale 1ns/1ps
`default_nettype none
module ssr_sync
  import ssr_pkg::*;
#(
  parameter int W = 1
)
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // levels
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  if (W < 1)
  begin : g_bad_width
    $error("ssr_sync width must be at least one");
  end

  logic [W-1:0] stage1;

  // stage1 feeds stage two only
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      stage1 <= '0;
      sync_out <= '0;
    end
    else
    begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end

endmodule : ssr_sync
`default_nettype wire

/* src/ssr_mode_map.sv */
// maps the mode pin strap to the reset voltage level codes
// assumes the mode value is already synchronised
`timescale 1ns/1ps
`default_nettype none
module ssr_mode_map
  import ssr_pkg::*;
(
  // strap in
  input wire logic [MODE_W-1:0] mode,
  // level codes out
  output ssr_level_t level
);

  assign level.core_code = CORE_CODE_BY_MODE[mode];
  assign level.pll_code = PLL_CODE_BY_MODE[mode];

endmodule : ssr_mode_map
`default_nettype wire

/* src/ssr_regs.sv */
// supply status and voltage level register bank on AHB-Lite
// assumes one AHB-Lite master, word transfers, pins from the analogue side
`timescale 1ns/1ps
`default_nettype none
module ssr_regs
  import ssr_pkg::*;
#(
  parameter int HADDR_W = 32
)
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [HADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // analogue side pins
  input wire ssr_supply_t supply_raw,
  input wire logic [MODE_W-1:0] mode_pins,
  // level codes to the regulators
  output ssr_level_t level,
  // interrupt
  output logic irq
);

  if (HADDR_W < 8)
  begin : g_bad_addr
    $error("ssr_regs address must be at least eight bits");
  end

  // synchronised pins
  ssr_supply_t supply;
  ssr_supply_t supply_q;
  logic [MODE_W-1:0] mode_sync;
  logic [EVENT_W+MODE_W-1:0] sync_bus;

  ssr_sync #(
    .W(EVENT_W + MODE_W)
  ) u_sync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .async_in({supply_raw, mode_pins}),
    .sync_out(sync_bus)
  );

  assign supply = sync_bus[EVENT_W+MODE_W-1:MODE_W];
  assign mode_sync = sync_bus[MODE_W-1:0];

  // strap decode
  ssr_level_t strap_level;

  ssr_mode_map u_map (
    .mode(mode_sync),
    .level(strap_level)
  );

  // strap capture after release, once the synchroniser holds the pins
  logic [1:0] settle_cnt;
  logic strap_done;
  wire load_strap = !strap_done && (settle_cnt == STRAP_SETTLE_CYCLES - 2'h1);

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      settle_cnt <= 2'h0;
      strap_done <= 1'b0;
    end
    else if (!strap_done)
    begin
      settle_cnt <= settle_cnt + 2'h1;
      strap_done <= load_strap;
    end
  end

  // bus stalls until the strap codes are loaded
  assign hreadyout = strap_done;
  assign hresp = 1'b0;

  // address phase
  wire addr_ok = hsel && htrans[1] && hready;
  wire [7:0] addr_lo = haddr[7:0];
  ssr_bus_req_t req;

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      req <= '0;
    end
    else if (hready)
    begin
      req.valid <= addr_ok;
      req.write <= hwrite;
      req.addr <= addr_lo;
    end
  end

  // write decode, data phase
  wire wr_en = req.valid && req.write && hready;
  wire wr_core = wr_en && (req.addr == CORE_VOLTAGE_LEVEL_OFS);
  wire wr_pll = wr_en && (req.addr == PLL_REGULATOR_LEVEL_OFS);
  wire wr_irq_status = wr_en && (req.addr == IRQ_STATUS_OFS);
  wire wr_irq_mask = wr_en && (req.addr == IRQ_MASK_OFS);

  // level registers; codes above the top step are kept as written
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      level.core_code <= CORE_CODE_RST;
      level.pll_code <= PLL_CODE_RST;
    end
    else if (load_strap)
    begin
      level <= strap_level;
    end
    else
    begin
      if (wr_core)
      begin
        level.core_code <= hwdata[CORE_CODE_W-1:0];
      end
      if (wr_pll)
      begin
        level.pll_code <= hwdata[PLL_CODE_W-1:0];
      end
    end
  end

  // status word, read-only, reserved bits zero
  logic [31:0] status_word;

  always_comb
  begin
    status_word = 32'h0000_0000;
    status_word[OSC_STABLE_BIT] = supply.osc_stable;
    status_word[PLL_GOOD_BIT] = supply.pll_supply_rail_good;
    status_word[CORE_GOOD_BIT] = supply.core_supply_rail_good;
    status_word[ANALOG_LIMIT_BIT] = supply.analog_switching_converter_limit;
    status_word[CORE_LIMIT_BIT] = supply.core_switching_converter_limit;
    status_word[ANALOG_SOFTSTART_BIT] = supply.analog_switching_converter_softstart;
    status_word[CORE_SOFTSTART_BIT] = supply.core_switching_converter_softstart;
  end

  // events: rising edge of any status flag
  logic [EVENT_W-1:0] irq_status;
  logic [EVENT_W-1:0] irq_mask;
  wire [EVENT_W-1:0] rise = supply & ~supply_q;
  wire [EVENT_W-1:0] w1c = wr_irq_status ? hwdata[EVENT_W-1:0] : '0;

  // set wins over a clear in the same cycle
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      supply_q <= '0;
      irq_status <= '0;
      irq_mask <= IRQ_MASK_RST;
    end
    else
    begin
      supply_q <= supply;
      irq_status <= (irq_status & ~w1c) | rise;
      if (wr_irq_mask)
      begin
        irq_mask <= hwdata[EVENT_W-1:0];
      end
    end
  end

  assign irq = |(irq_status & irq_mask);

  // read mux, sampled at the address phase
  wire sel_status = (addr_lo == SUPPLY_HEALTH_STATUS_OFS);
  wire sel_core = (addr_lo == CORE_VOLTAGE_LEVEL_OFS);
  wire sel_pll = (addr_lo == PLL_REGULATOR_LEVEL_OFS);
  wire sel_irq_status = (addr_lo == IRQ_STATUS_OFS);
  wire sel_irq_mask = (addr_lo == IRQ_MASK_OFS);
  wire [31:0] rd_status = {32{sel_status}} & status_word;
  wire [31:0] rd_core = {32{sel_core}} & {25'h0, level.core_code};
  wire [31:0] rd_pll = {32{sel_pll}} & {29'h0, level.pll_code};
  wire [31:0] rd_irqs = {32{sel_irq_status}} & {25'h0, irq_status};
  wire [31:0] rd_irqm = {32{sel_irq_mask}} & {25'h0, irq_mask};
  wire [31:0] rd_mux = rd_status | rd_core | rd_pll | rd_irqs | rd_irqm;
  wire rd_take = addr_ok && !hwrite;

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      hrdata <= 32'h0000_0000;
    end
    else if (rd_take)
    begin
      hrdata <= rd_mux;
    end
  end

  // checks
  wire rd_stat = rd_take && sel_status;

  a_osc_stable_read: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    rd_stat |=> (hrdata[OSC_STABLE_BIT] == $past(supply.osc_stable))
      && (hrdata[31:25] == 7'h00))
    else $error("oscillator stable bit misread");

  a_status_read_only: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (wr_en && req.addr == SUPPLY_HEALTH_STATUS_OFS) |=> $stable(level) && $stable(irq_mask))
    else $error("status write changed state");

  a_pll_good_read: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    rd_stat |=> hrdata[PLL_GOOD_BIT] == $past(supply.pll_supply_rail_good))
    else $error("pll rail good bit misread");

  a_core_good_read: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    rd_stat |=> hrdata[CORE_GOOD_BIT] == $past(supply.core_supply_rail_good))
    else $error("core rail good bit misread");

  a_analog_limit_read: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    rd_stat |=> hrdata[ANALOG_LIMIT_BIT] == $past(supply.analog_switching_converter_limit))
    else $error("analog limit bit misread");

  a_core_limit_read: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    rd_stat |=> hrdata[CORE_LIMIT_BIT] == $past(supply.core_switching_converter_limit))
    else $error("core limit bit misread");

  a_analog_soft_read: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    rd_stat |=> hrdata[ANALOG_SOFTSTART_BIT]
      == $past(supply.analog_switching_converter_softstart))
    else $error("analog softstart bit misread");

  a_core_soft_read: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    rd_stat |=> hrdata[CORE_SOFTSTART_BIT]
      == $past(supply.core_switching_converter_softstart))
    else $error("core softstart bit misread");

  a_core_code_write: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    wr_core |=> level.core_code == $past(hwdata[6:0]))
    else $error("core code not written");

  a_strap_load: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    load_strap |=> strap_done && (level == $past(strap_level)))
    else $error("strap codes not loaded");

  a_strap_timing: assert property (
    @(posedge core_clk)
    $rose(rst_n) |-> !strap_done [*3] ##1 strap_done)
    else $error("strap load not three cycles after release");

  a_pll_code_write: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    wr_pll |=> level.pll_code == $past(hwdata[2:0]))
    else $error("pll code not written");

  a_level_reserved: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    rd_take && (sel_core || sel_pll) |=> hrdata[31:7] == 25'h0
      && (!$past(sel_pll) || hrdata[6:3] == 4'h0))
    else $error("reserved level bits not zero");

  a_event_set_wins: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (|(rise & w1c)) |=> (|(irq_status & $past(rise & w1c))))
    else $error("event lost under clear");

  // reserved status bits must stay dark whatever the pins do
  a_status_reserved: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    rd_stat |=> (hrdata & ~32'h0109_0303) == 32'h0000_0000)
    else $error("reserved status bits not zero");

  a_unmapped_zero: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    rd_take && !(sel_status || sel_core || sel_pll || sel_irq_status || sel_irq_mask)
      |=> hrdata == 32'h0000_0000)
    else $error("unmapped read not zero");

  a_core_code_hold: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    !wr_core && !load_strap |=> $stable(level.core_code))
    else $error("core code changed without write");

  a_pll_code_hold: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    !wr_pll && !load_strap |=> $stable(level.pll_code))
    else $error("pll code changed without write");

  a_rdata_stands: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    !rd_take |=> $stable(hrdata))
    else $error("read data moved without read");

  a_ready_after_strap: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    strap_done |=> strap_done && hreadyout && !hresp)
    else $error("bus ready dropped after strap");

  a_event_set: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (|rise) |=> ((irq_status & $past(rise)) == $past(rise)))
    else $error("rising flag did not set its event");

  a_event_clear: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (|(w1c & ~rise)) |=> ((irq_status & $past(w1c & ~rise)) == '0))
    else $error("event not cleared by write one");

  a_mask_write: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    wr_irq_mask |=> irq_mask == $past(hwdata[EVENT_W-1:0]))
    else $error("mask not written");

endmodule : ssr_regs
`default_nettype wire

/* verif/ssr_regs_tb.sv */
// bench for the supply status and level register bank
// assumes ssr_regs alone on an ahb-lite bus, with this bench as the only master
`timescale 1ns/1ps
`default_nettype none
module ssr_regs_tb
  import ssr_pkg::*;
;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [MODE_W-1:0] mode_pins = '0;
  ssr_supply_t supply_raw = '0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  ssr_level_t level;
  logic irq;
  logic [31:0] rd;
  int fails = 0;
  int cmp_count = 0;
  int bit_pos [7] = '{0, 1, 8, 9, 16, 19, 24};

  ssr_regs #(.HADDR_W(32)) dut (
    .core_clk(core_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .supply_raw(supply_raw),
    .mode_pins(mode_pins), .level(level), .irq(irq)
  );

  initial
  begin
    forever #20 core_clk = ~core_clk;
  end

  task automatic wrap_up();
    begin
      if (fails == 0 && cmp_count > 0)
      begin
        $display("TB: PASS");
      end
      else
      begin
        $display("TB: FAIL");
      end
      $finish;
    end
  endtask : wrap_up

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    begin
      cmp_count++;
      if (seen !== exp)
      begin
        fails++;
        $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
    end
  endtask : check

  // ready looked at half a cycle early; the slave only moves it after a rising edge
  task automatic wait_ready();
    int n;
    begin
      n = 0;
      do
      begin
        @(negedge core_clk);
        n++;
      end
      while (hreadyout !== 1'b1 && n < 64);
      if (hreadyout !== 1'b1)
      begin
        fails++;
        $display("MISMATCH hreadyout expected 1 seen %b", hreadyout);
        wrap_up();
      end
      else
      begin
        @(posedge core_clk);
      end
    end
  endtask : wait_ready

  // entered just after a rising edge
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    begin
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      hwrite <= wr;
      hsize <= 3'h2;
      htrans <= 2'h2;
      wait_ready();
      htrans <= 2'h0;
      hwdata <= wd;
      wait_ready();
      rd = hrdata;
    end
  endtask : xfer

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
    begin
      xfer(1'b0, a, 32'h0);
      check(what, rd, exp);
    end
  endtask : rd_chk

  task automatic do_reset(input logic [1:0] m);
    begin
      rst_n <= 1'b0;
      mode_pins <= m;
      repeat (19) @(posedge core_clk);
      @(negedge core_clk);
      check("ready in reset", {31'h0, hreadyout}, 32'h0);
      @(posedge core_clk);
      rst_n <= 1'b1;
    end
  endtask : do_reset

  initial
  begin
    for (int m = 0; m < 4; m++)
    begin
      do_reset(2'(m));
      rd_chk(CORE_VOLTAGE_LEVEL_OFS, {25'h0, CORE_CODE_BY_MODE[m]}, "core reset");
      rd_chk(PLL_REGULATOR_LEVEL_OFS, {29'h0, PLL_CODE_BY_MODE[m]}, "pll reset");
      check("level", {22'h0, level}, {22'h0, CORE_CODE_BY_MODE[m], PLL_CODE_BY_MODE[m]});
    end
    rd_chk(IRQ_MASK_OFS, 32'h0, "mask reset");
    // one pin at a time, so a swapped pair of fields shows
    for (int i = 0; i < 7; i++)
    begin
      supply_raw <= ssr_supply_t'(7'h1 << i);
      repeat (4) @(posedge core_clk);
      rd_chk(SUPPLY_HEALTH_STATUS_OFS, 32'h1 << bit_pos[i], "status walk");
    end
    supply_raw <= ssr_supply_t'(7'h7f);
    repeat (4) @(posedge core_clk);
    rd_chk(SUPPLY_HEALTH_STATUS_OFS, 32'h0109_0303, "status all");
    xfer(1'b1, SUPPLY_HEALTH_STATUS_OFS, 32'hffff_ffff);
    supply_raw <= '0;
    repeat (4) @(posedge core_clk);
    rd_chk(SUPPLY_HEALTH_STATUS_OFS, 32'h0, "status write");
    // ramp from the mode 3 reset code, one code every 27 cycles (1080 ns)
    for (int c = 8'h3d; c <= 8'h46; c++)
    begin
      xfer(1'b1, CORE_VOLTAGE_LEVEL_OFS, 32'(c));
      repeat (25) @(posedge core_clk);
    end
    rd_chk(CORE_VOLTAGE_LEVEL_OFS, 32'h46, "core top code");
    xfer(1'b1, CORE_VOLTAGE_LEVEL_OFS, 32'hffff_ff47);
    rd_chk(CORE_VOLTAGE_LEVEL_OFS, 32'h47, "core reserved");
    xfer(1'b1, PLL_REGULATOR_LEVEL_OFS, 32'hffff_fff7);
    rd_chk(PLL_REGULATOR_LEVEL_OFS, 32'h7, "pll reserved");
    xfer(1'b1, PLL_REGULATOR_LEVEL_OFS, 32'h0);
    rd_chk(PLL_REGULATOR_LEVEL_OFS, 32'h0, "pll code");
    check("level out", {22'h0, level}, {22'h0, 7'h47, 3'h0});
    xfer(1'b1, 8'h44, 32'hffff_ffff);
    rd_chk(8'h44, 32'h0, "unmapped");
    check("hresp", {31'h0, hresp}, 32'h0);
    // events from the walk above are still pending, so clear them first
    xfer(1'b1, IRQ_STATUS_OFS, 32'h7f);
    rd_chk(IRQ_STATUS_OFS, 32'h0, "irq clear all");
    supply_raw <= ssr_supply_t'(7'h40);
    repeat (5) @(posedge core_clk);
    rd_chk(IRQ_STATUS_OFS, 32'h40, "irq set");
    xfer(1'b1, IRQ_MASK_OFS, 32'h3f);
    @(negedge core_clk);
    check("irq other mask", {31'h0, irq}, 32'h0);
    @(posedge core_clk);
    xfer(1'b1, IRQ_MASK_OFS, 32'h40);
    @(negedge core_clk);
    check("irq unmasked", {31'h0, irq}, 32'h1);
    @(posedge core_clk);
    rd_chk(IRQ_MASK_OFS, 32'h40, "mask read");
    xfer(1'b1, IRQ_STATUS_OFS, 32'h40);
    @(negedge core_clk);
    check("irq cleared", {31'h0, irq}, 32'h0);
    @(posedge core_clk);
    // a falling pin is no event
    supply_raw <= '0;
    repeat (5) @(posedge core_clk);
    rd_chk(IRQ_STATUS_OFS, 32'h0, "irq on fall");
    // pin rise lands in the same cycle as the clearing write: set must win
    supply_raw <= ssr_supply_t'(7'h01);
    @(posedge core_clk);
    xfer(1'b1, IRQ_STATUS_OFS, 32'h01);
    rd_chk(IRQ_STATUS_OFS, 32'h01, "set wins");
    wrap_up();
  end
endmodule : ssr_regs_tb
`default_nettype wire
